// *** inc/port_fgh_regs.svh ***
`ifndef PORT_FGH_REGS_SVH
`define PORT_FGH_REGS_SVH

// register byte addresses (word registers, big-endian byte lanes)
`define PF_DATA_ADDR 32'hffff83a6
`define PG_DATA_ADDR 32'hffff83ae
`define PH_LVL_ADDR 32'hffff83b6

// reset values
`define PF_DATA_RST 16'hf000
`define PG_DATA_RST 16'h0000

// port f: writable field and read-only ones above it
`define PF_WR_MASK 16'h0fff
`define PF_RO_ONES 16'hf000

// widths
`define PF_PINS 12
`define PG_PINS 16
`define PH_PINS 16
`define BUS_PINS 37

// byte lane handling
`define LANE_BYTE_MASK 16'h00ff
`define LANE_SHIFT 8
`define READ_IDLE 16'h0000

`endif

// *** inc/port_fgh_pkg.sv ***
package port_fgh_pkg;

  // one register bus request, all fields valid in the same cycle
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic byte_acc;
  } bus_req_t;

  // per-pin controls from the pin-function block
  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] general;
  } pin_ctl_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_F,
    SEL_G,
    SEL_H
  } reg_sel_t;

endpackage : port_fgh_pkg

// *** hw/port_fgh_data.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "port_fgh_regs.svh"

// Operation
// - f/g output pin with general function drives written data at once
// - f/g general output reads back the stored bit, not the pin
// - f/g general input reads the pin; writes only store
// - direction 0 with alternate function reads pin; write only stores
// - direction 1 with alternate function reads stored bit, no drive
// - port f register 16 bits, bits 15-12 read one, reset f000
// - port g register 16 bits all read/write, reset zero
// - f/g cleared by power-on reset and hardware standby only
// - any 8 or 16 bit access takes two bus cycles
// - port h register read-only; writes dropped, pins untouched
// - port h reads pin level, or one while channel is sampled
// - port h has no reset; it always follows the pins
// - output kill low floats general-output address and data pins
// - output kill acts combinationally, not tied to bus cycles
// - port f has 12 bidirectional pins with mode-dependent alternates
// - port g has 16 bidirectional pins shared with alternates
module port_fgh_data
  import port_fgh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic hw_standby,
  input wire bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  input wire pin_ctl_t port_f_ctl,
  input wire pin_ctl_t port_g_ctl,
  input wire logic [`PF_PINS-1:0] port_f_pin_in,
  output logic [`PF_PINS-1:0] port_f_pin_out,
  output logic [`PF_PINS-1:0] port_f_pin_oe_n,
  input wire logic [`PG_PINS-1:0] port_g_pin_in,
  output logic [`PG_PINS-1:0] port_g_pin_out,
  output logic [`PG_PINS-1:0] port_g_pin_oe_n,
  input wire logic [`PH_PINS-1:0] port_h_pin_in,
  input wire logic [`PH_PINS-1:0] analog_input_channel,
  input wire logic bus_pin_output_kill_n,
  input wire logic [`BUS_PINS-1:0] bus_pin_gen_out,
  output logic [`BUS_PINS-1:0] bus_pin_oe_n
);

  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [31:0] base);
    addr_hit = (a[31:1] == base[31:1]);
  endfunction : addr_hit

  // even address is the upper byte lane
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input bus_req_t r);
    logic [15:0] hi_mask;
    hi_mask = `LANE_BYTE_MASK << `LANE_SHIFT;
    if (!r.byte_acc) begin
      lane_merge = r.wdata;
    end else if (r.addr[0]) begin
      lane_merge = (old & hi_mask) | (r.wdata & `LANE_BYTE_MASK);
    end else begin
      lane_merge = (old & `LANE_BYTE_MASK) |
                   ((r.wdata & `LANE_BYTE_MASK) << `LANE_SHIFT);
    end
  endfunction : lane_merge

  function automatic logic [15:0] lane_pick(input logic [15:0] v,
                                            input bus_req_t r);
    if (!r.byte_acc) begin
      lane_pick = v;
    end else if (r.addr[0]) begin
      lane_pick = v & `LANE_BYTE_MASK;
    end else begin
      lane_pick = v >> `LANE_SHIFT;
    end
  endfunction : lane_pick

  logic [15:0] pf_reg;
  logic [15:0] pf_next;
  logic [15:0] pg_reg;
  logic [15:0] pg_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [`PF_PINS-1:0] pf_oe_n_reg;
  logic [`PG_PINS-1:0] pg_oe_n_reg;

  // address decode
  wire logic hit_f = addr_hit(bus_req.addr, `PF_DATA_ADDR);
  wire logic hit_g = addr_hit(bus_req.addr, `PG_DATA_ADDR);
  wire logic hit_h = addr_hit(bus_req.addr, `PH_LVL_ADDR);
  wire reg_sel_t sel = hit_f ? SEL_F : hit_g ? SEL_G :
                       hit_h ? SEL_H : SEL_NONE;
  wire logic wr_f = bus_req.wr && (sel == SEL_F);
  wire logic wr_g = bus_req.wr && (sel == SEL_G);
  wire logic wr_h = bus_req.wr && (sel == SEL_H);
  wire logic rd_any = bus_req.rd;
  wire logic init_now = sys_rst || hw_standby;

  // per-pin control slices from the pin-function block
  wire logic [`PF_PINS-1:0] pf_dir = port_f_ctl.dir[`PF_PINS-1:0];
  wire logic [`PF_PINS-1:0] pf_gen = port_f_ctl.general[`PF_PINS-1:0];
  wire logic [`PG_PINS-1:0] pg_dir = port_g_ctl.dir;
  wire logic [`PG_PINS-1:0] pg_gen = port_g_ctl.general;

  // readback: direction 1 shows the stored bit, direction 0 the pin
  wire logic [`PF_PINS-1:0] pf_view_lo =
    (pf_dir & pf_reg[`PF_PINS-1:0]) |
    (~pf_dir & port_f_pin_in);
  wire logic [15:0] pf_view =
    `PF_RO_ONES | {4'h0, pf_view_lo};
  wire logic [15:0] pg_view =
    (pg_dir & pg_reg) | (~pg_dir & port_g_pin_in);
  // sampling forces ones; no storage, so no reset value exists
  wire logic [15:0] ph_view =
    port_h_pin_in | analog_input_channel;

  wire logic [15:0] sel_view =
    (sel == SEL_F) ? pf_view :
    (sel == SEL_G) ? pg_view :
    (sel == SEL_H) ? ph_view : `READ_IDLE;

  // stored bits follow every write, whatever the pin function
  assign pf_next = wr_f ?
    ((lane_merge(pf_reg, bus_req) & `PF_WR_MASK) | `PF_RO_ONES) :
    pf_reg;
  assign pg_next = wr_g ? lane_merge(pg_reg, bus_req) : pg_reg;
  // data stands only in the cycle after the strobe
  assign rdata_next = rd_any ?
    lane_pick(sel_view, bus_req) : `READ_IDLE;

  // a pin drives only when output and general function both hold
  wire logic [`PF_PINS-1:0] pf_oe_n_next =
    ~(pf_dir & pf_gen);
  wire logic [`PG_PINS-1:0] pg_oe_n_next =
    ~(pg_dir & pg_gen);

  // watchdog reset and the soft standby/sleep states never reach here,
  // so contents survive them
  always_ff @(posedge ref_clk) begin
    if (init_now) begin
      pf_reg <= `PF_DATA_RST;
      pg_reg <= `PG_DATA_RST;
    end else if (clk_en) begin
      pf_reg <= pf_next;
      pg_reg <= pg_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= `READ_IDLE;
      pf_oe_n_reg <= '1;
      pg_oe_n_reg <= '1;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
      pf_oe_n_reg <= pf_oe_n_next;
      pg_oe_n_reg <= pg_oe_n_next;
    end
  end

  assign bus_rdata = rdata_reg;
  // the data register itself feeds the pins, so a write shows next edge
  assign port_f_pin_out = pf_reg[`PF_PINS-1:0];
  assign port_g_pin_out = pg_reg;
  assign port_f_pin_oe_n = pf_oe_n_reg;
  assign port_g_pin_oe_n = pg_oe_n_reg;

  // the kill path must not wait for a clock edge, so it is the one output
  // that is not registered
  assign bus_pin_oe_n =
    ~(bus_pin_gen_out & {`BUS_PINS{bus_pin_output_kill_n}});

  sequence s_read_req;
    clk_en && rd_any;
  endsequence

  sequence s_idle_step;
    clk_en && !rd_any;
  endsequence

  a_read_two_cycle: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    s_read_req ##1 s_idle_step |=> bus_rdata == `READ_IDLE)
    else $error("read data held beyond its one cycle");

  a_f_read_view: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_f && !bus_req.byte_acc) |=>
      bus_rdata[`PF_PINS-1:0] == $past(pf_view_lo))
    else $error("port f readback does not follow direction");

  a_f_top_ones: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_f && !bus_req.byte_acc) |=>
      bus_rdata[15:12] == 4'hf)
    else $error("port f upper bits did not read as one");

  a_f_write_drive: assert property (
    @(posedge ref_clk) disable iff (init_now)
    (clk_en && wr_f && !bus_req.byte_acc) |=>
      port_f_pin_out == $past(bus_req.wdata[`PF_PINS-1:0]))
    else $error("port f write not on pins");

  a_g_input_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_g && !bus_req.byte_acc && pg_dir == '0) |=>
      bus_rdata == $past(port_g_pin_in))
    else $error("port g input read did not return pins");

  a_g_alt_float: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && (pg_dir & ~pg_gen) == pg_dir) ##1 clk_en |->
      (port_g_pin_oe_n | ~$past(pg_dir)) == '1)
    else $error("port g pin drives while not general output");

  a_h_sample_one: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_h && !bus_req.byte_acc) |=>
      bus_rdata == $past(port_h_pin_in | analog_input_channel))
    else $error("port h read wrong level");

  a_h_write_none: assert property (
    @(posedge ref_clk) disable iff (init_now)
    (clk_en && wr_h) |=> $stable(pf_reg) && $stable(pg_reg))
    else $error("port h write changed stored data");

  a_reset_values: assert property (
    @(posedge ref_clk)
    init_now |=> pf_reg == `PF_DATA_RST && pg_reg == `PG_DATA_RST)
    else $error("data registers not initialised");

  a_kill_float: assert property (
    @(posedge ref_clk)
    !bus_pin_output_kill_n |-> bus_pin_oe_n == '1)
    else $error("bus pins driven while output kill low");

  a_kill_pass: assert property (
    @(posedge ref_clk)
    bus_pin_output_kill_n |-> bus_pin_oe_n == ~bus_pin_gen_out)
    else $error("bus pins not following general output select");

  a_g_output_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_g && !bus_req.byte_acc && pg_dir == '1) |=>
      bus_rdata == $past(pg_reg))
    else $error("port g output read did not return stored bits");

  a_f_input_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_f && !bus_req.byte_acc && pf_dir == '0) |=>
      bus_rdata[`PF_PINS-1:0] == $past(port_f_pin_in))
    else $error("port f input read did not return pins");

  a_g_write_store: assert property (
    @(posedge ref_clk) disable iff (init_now)
    (clk_en && wr_g && !bus_req.byte_acc) |=>
      pg_reg == $past(bus_req.wdata))
    else $error("port g word write not stored");

  a_f_top_stored: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    pf_reg[15:12] == 4'hf)
    else $error("port f upper stored bits not one");

  a_f_input_float: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en |=> (port_f_pin_oe_n | $past(pf_dir)) == '1)
    else $error("port f input pin is driven");

  a_f_drive_enable: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en |=> port_f_pin_oe_n == ~($past(pf_dir) & $past(pf_gen)))
    else $error("port f drive enable wrong");

  a_g_drive_enable: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en |=> port_g_pin_oe_n == ~($past(pg_dir) & $past(pg_gen)))
    else $error("port g drive enable wrong");

  // clock enable low must freeze the stored data outside initialisation
  a_data_freeze: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!clk_en && !init_now) |=> $stable(pf_reg) && $stable(pg_reg))
    else $error("data registers moved while clock enable low");

  a_read_idle: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && !rd_any) |=> bus_rdata == `READ_IDLE)
    else $error("read data present without a read");

  a_byte_upper_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && bus_req.byte_acc) |=> bus_rdata[15:8] == 8'h00)
    else $error("byte read upper lane not zero");

  a_h_byte_low: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_h && bus_req.byte_acc && bus_req.addr[0]) |=>
      bus_rdata[7:0] == $past(port_h_pin_in[7:0] | analog_input_channel[7:0]))
    else $error("port h low byte read wrong level");

  a_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && sel == SEL_NONE) |=> bus_rdata == `READ_IDLE)
    else $error("unmapped read returned data");

  a_h_write_pins: assert property (
    @(posedge ref_clk) disable iff (init_now)
    (clk_en && wr_h) |=>
      $stable(port_f_pin_out) && $stable(port_g_pin_out))
    else $error("port h write changed pin outputs");

  a_g_alt_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_g && !bus_req.byte_acc &&
     pg_dir == '0 && pg_gen == '0) |=>
      bus_rdata == $past(port_g_pin_in))
    else $error("port g alternate input read did not return pins");

  a_f_alt_out_read: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (clk_en && rd_any && hit_f && !bus_req.byte_acc &&
     pf_dir == '1 && pf_gen == '0) |=>
      bus_rdata[`PF_PINS-1:0] == $past(pf_reg[`PF_PINS-1:0]))
    else $error("port f alternate output read wrong");

  // all port f and g pins are released while reset holds, whatever the controls say
  a_reset_float: assert property (
    @(posedge ref_clk)
    sys_rst |=> port_f_pin_oe_n == '1 && port_g_pin_oe_n == '1)
    else $error("pins driven after reset");

endmodule : port_fgh_data

`default_nettype wire

// *** dv/pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// far-side pins: a released pin shows only what the outside world drives
module pin_model #(
  parameter int W = 16
) (
  input wire logic [W-1:0] drv_out,
  input wire logic [W-1:0] drv_oe_n,
  input wire logic [W-1:0] ext_level,
  output logic [W-1:0] pin_level
);
  // the device owns a pin only where its enable is low
  assign pin_level = (drv_out & ~drv_oe_n) | (ext_level & drv_oe_n);
endmodule : pin_model
`default_nettype wire

// *** dv/port_fgh_data_and_output_disable_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "port_fgh_regs.svh"
module port_fgh_data_and_output_disable_bench;
  import port_fgh_pkg::*;
  logic ref_clk, sys_rst, clk_en, hw_standby, kill_n;
  bus_req_t req;
  pin_ctl_t fc, gc;
  logic [15:0] rdata, g_out, g_oe_n, g_in, g_ext, h_pin, h_smp;
  logic [11:0] f_out, f_oe_n, f_in, f_ext;
  logic [36:0] gen_out, bus_oe_n;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  port_fgh_data i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .hw_standby(hw_standby), .bus_req(req), .bus_rdata(rdata),
    .port_f_ctl(fc), .port_g_ctl(gc), .port_f_pin_in(f_in),
    .port_f_pin_out(f_out), .port_f_pin_oe_n(f_oe_n), .port_g_pin_in(g_in),
    .port_g_pin_out(g_out), .port_g_pin_oe_n(g_oe_n), .port_h_pin_in(h_pin),
    .analog_input_channel(h_smp), .bus_pin_output_kill_n(kill_n),
    .bus_pin_gen_out(gen_out), .bus_pin_oe_n(bus_oe_n));
  pin_model #(.W(12)) i_f_pins (.drv_out(f_out), .drv_oe_n(f_oe_n),
    .ext_level(f_ext), .pin_level(f_in));
  pin_model #(.W(16)) i_g_pins (.drv_out(g_out), .drv_oe_n(g_oe_n),
    .ext_level(g_ext), .pin_level(g_in));
  always #50 ref_clk = ~ref_clk;
  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // a hang is cut short well beyond the fewer than one hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bus(input logic [36:0] got, input logic [36:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t bus enables %h expected %h", $time, got, exp);
    end
  endtask : chk_bus
  task automatic bus_wr(input logic [31:0] a, input logic [15:0] d,
                        input logic b);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.byte_acc <= b;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
    #1;
  endtask : bus_wr
  task automatic rd_chk(input logic [31:0] a, input logic b,
                        input logic [15:0] exp);
    @(posedge ref_clk);
    req.addr <= a;
    req.byte_acc <= b;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  // pin levels may pass a synchroniser, so let a few edges go by
  task automatic set_g(input pin_ctl_t c, input logic [15:0] e);
    @(posedge ref_clk);
    gc <= c;
    g_ext <= e;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : set_g
  initial begin
    ref_clk = 0; sys_rst = 1; clk_en = 1; hw_standby = 0; kill_n = 1;
    req = '0; fc = {16'hffff, 16'hffff}; gc = {16'hffff, 16'hffff};
    f_ext = 12'h555; g_ext = 16'h1234; h_pin = 16'h0000; h_smp = 16'h0000;
    gen_out = 37'h0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(`PF_DATA_ADDR, 1'b0, 16'hf000);
    rd_chk(`PG_DATA_ADDR, 1'b0, 16'h0000);
    bus_wr(`PF_DATA_ADDR, 16'hffff, 1'b0);
    chk({4'h0, f_in}, 16'h0fff);
    rd_chk(`PF_DATA_ADDR, 1'b0, 16'hffff);
    bus_wr(`PF_DATA_ADDR, 16'h0abc, 1'b0);
    rd_chk(`PF_DATA_ADDR, 1'b0, 16'hfabc);
    bus_wr(`PG_DATA_ADDR, 16'h5a5a, 1'b0);
    chk(g_in, 16'h5a5a);
    bus_wr(`PG_DATA_ADDR, 16'h00c3, 1'b1);
    rd_chk(`PG_DATA_ADDR, 1'b0, 16'hc35a);
    rd_chk(`PG_DATA_ADDR + 32'h1, 1'b1, 16'h005a);
    bus_wr(32'hffff83c0, 16'hffff, 1'b0);
    rd_chk(32'hffff83c0, 1'b0, 16'h0000);
    bus_wr(`PH_LVL_ADDR, 16'hffff, 1'b0);
    @(posedge ref_clk);
    h_pin <= 16'h00f0;
    h_smp <= 16'h0300;
    repeat (3) @(posedge ref_clk);
    rd_chk(`PH_LVL_ADDR, 1'b0, 16'h03f0);
    @(posedge ref_clk);
    h_pin <= 16'h0a0a;
    h_smp <= 16'h0000;
    repeat (3) @(posedge ref_clk);
    rd_chk(`PH_LVL_ADDR, 1'b0, 16'h0a0a);
    set_g({16'h0000, 16'hffff}, 16'h1234);
    rd_chk(`PG_DATA_ADDR, 1'b0, 16'h1234);
    bus_wr(`PG_DATA_ADDR, 16'hffff, 1'b0);
    chk(g_in, 16'h1234);
    set_g({16'h0000, 16'h0000}, 16'h4321);
    rd_chk(`PG_DATA_ADDR, 1'b0, 16'h4321);
    set_g({16'hffff, 16'h0000}, 16'h4321);
    rd_chk(`PG_DATA_ADDR, 1'b0, 16'hffff);
    bus_wr(`PG_DATA_ADDR, 16'h0f0f, 1'b0);
    chk(g_in, 16'h4321);
    rd_chk(`PG_DATA_ADDR, 1'b0, 16'h0f0f);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    bus_wr(`PG_DATA_ADDR, 16'h1111, 1'b0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd_chk(`PG_DATA_ADDR, 1'b0, 16'h0f0f);
    @(posedge ref_clk);
    gen_out <= 37'h10_0000_0001;
    kill_n <= 1'b0;
    #1;
    chk_bus(bus_oe_n, 37'h1f_ffff_ffff);
    @(posedge ref_clk);
    kill_n <= 1'b1;
    #1;
    chk_bus(bus_oe_n, 37'h0f_ffff_fffe);
    @(posedge ref_clk);
    hw_standby <= 1'b1;
    @(posedge ref_clk);
    hw_standby <= 1'b0;
    set_g({16'hffff, 16'hffff}, 16'h1234);
    rd_chk(`PF_DATA_ADDR, 1'b0, 16'hf000);
    rd_chk(`PG_DATA_ADDR, 1'b0, 16'h0000);
    chk(g_in, 16'h0000);
    print_verdict();
  end
endmodule : port_fgh_data_and_output_disable_bench
`default_nettype wire
